// ===== mefe_top.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module mefe_top
  import mefe_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  input wire logic SAMPLE_VALID,
  input wire logic signed [SAMPLE_W-1:0] SUMMED_PHASE_CURRENT,
  input wire logic signed [SAMPLE_W-1:0] NEUTRAL_CURRENT_SAMPLE,
  input wire logic CURRENT_PEAK_DONE,
  input wire logic VOLTAGE_PEAK_DONE,
  input wire logic [2:0] TOTAL_ACTIVE_BIT30,
  input wire logic [2:0] FUND_ACTIVE_BIT30,
  input wire logic [2:0] TOTAL_REACTIVE_BIT30,
  input wire logic [2:0] FUND_REACTIVE_BIT30,
  input wire logic [2:0] APPARENT_BIT30,
  input wire logic LINE_CYCLE_MODE,
  input wire logic LINE_CYCLE_DONE,
  input wire logic [2:0] TOTAL_ACTIVE_SIGN,
  input wire logic [2:0] FUND_ACTIVE_SIGN,
  input wire logic PULSE1_SUM_SIGN,
  input wire logic TOTAL_REACTIVE_SIGN_A,
  input wire logic FUND_REACTIVE_SIGN_A,
  output logic IRQ0_N,
  output logic SECOND_IRQ_LINE_N
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  mefe_wr_s wr;
  mefe_rd_s rd;
  logic [31:0] rd_data;

  mefe_ahb_slave u_ahb (
    .clk(CLK),
    .rst_n(RST_N),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hreadyout(HREADYOUT),
    .hrdata(HRDATA),
    .hresp(HRESP),
    .wr(wr),
    .rd(rd),
    .rd_data(rd_data)
  );

  logic wr_status_low;
  logic wr_status_high;
  logic wr_enable_low;
  logic wr_enable_high;
  logic wr_threshold;
  logic wr_accumulation_mode_reg;

  assign wr_status_low = wr.en & (wr.idx == IDX_STATUS_LOW);
  assign wr_status_high = wr.en & (wr.idx == IDX_STATUS_HIGH);
  assign wr_enable_low = wr.en & (wr.idx == IDX_ENABLE_LOW);
  assign wr_enable_high = wr.en & (wr.idx == IDX_ENABLE_HIGH);
  assign wr_threshold = wr.en & (wr.idx == IDX_THRESHOLD);
  assign wr_accumulation_mode_reg = wr.en & (wr.idx == IDX_ACCUMULATION_MODE_REG);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [31:0] enable_low_r;
  logic [31:0] enable_low_nxt;
  logic [31:0] enable_high_r;
  logic [31:0] enable_high_nxt;
  logic [31:0] threshold_r;
  logic [31:0] threshold_nxt;
  logic [31:0] accumulation_mode_reg_r;
  logic [31:0] accumulation_mode_reg_nxt;

  // Unused enable bits are kept at zero so they can never gate a stray flag.
  always_comb begin
    enable_low_nxt = enable_low_r;
    if (wr_enable_low) begin
      enable_low_nxt = wr.data & LOW_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_low_r <= ENABLE_RST;
    end else begin
      enable_low_r <= enable_low_nxt;
    end
  end

  always_comb begin
    enable_high_nxt = enable_high_r;
    if (wr_enable_high) begin
      enable_high_nxt = wr.data & HIGH_ENABLE_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      enable_high_r <= ENABLE_RST;
    end else begin
      enable_high_r <= enable_high_nxt;
    end
  end

  // Only the sample width is kept; the upper bits read back as zero.
  always_comb begin
    threshold_nxt = threshold_r;
    if (wr_threshold) begin
      threshold_nxt = {4'h0, wr.data[SAMPLE_W-1:0]};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      threshold_r <= THRESHOLD_RST;
    end else begin
      threshold_r <= threshold_nxt;
    end
  end

  always_comb begin
    accumulation_mode_reg_nxt = accumulation_mode_reg_r;
    if (wr_accumulation_mode_reg) begin
      accumulation_mode_reg_nxt = wr.data & ACCUMULATION_MODE_REG_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      accumulation_mode_reg_r <= ACCUMULATION_MODE_REG_RST;
    end else begin
      accumulation_mode_reg_r <= accumulation_mode_reg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Energy accumulator half-full detection

  logic [14:0] bit30_all;
  logic [14:0] bit30_chg;
  logic [4:0] half_full_evt;

  assign bit30_all = {APPARENT_BIT30, FUND_REACTIVE_BIT30, TOTAL_REACTIVE_BIT30,
                      FUND_ACTIVE_BIT30, TOTAL_ACTIVE_BIT30};

  // Energy registers move slowly, so every clock is a valid sample.
  mefe_change_det #(.W(15)) u_bit30 (
    .clk(CLK),
    .rst_n(RST_N),
    .valid(1'b1),
    .d(bit30_all),
    .chg(bit30_chg)
  );

  // One group per accumulator kind, each holding phases A, B and C.
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_half_full
      assign half_full_evt[g] = |bit30_chg[3*g +: 3];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Power sign detection

  logic [2:0] active_sign;
  logic react_sign_a;
  logic [4:0] sign_all;
  logic [4:0] sign_chg;

  // A change of the source select can itself look like a sign change.
  assign active_sign = accumulation_mode_reg_r[ACC_ACT_SEL_BIT] ? FUND_ACTIVE_SIGN
                                                  : TOTAL_ACTIVE_SIGN;
  assign react_sign_a = accumulation_mode_reg_r[ACC_REACT_SEL_BIT] ? FUND_REACTIVE_SIGN_A
                                                     : TOTAL_REACTIVE_SIGN_A;
  assign sign_all = {react_sign_a, PULSE1_SUM_SIGN, active_sign};

  mefe_change_det #(.W(5)) u_sign (
    .clk(CLK),
    .rst_n(RST_N),
    .valid(1'b1),
    .d(sign_all),
    .chg(sign_chg)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Neutral current mismatch

  logic signed [SAMPLE_W:0] cur_diff;
  logic [SAMPLE_W:0] cur_mag;
  logic mismatch_evt;

  assign cur_diff = (SAMPLE_W + 1)'(SUMMED_PHASE_CURRENT)
                    - (SAMPLE_W + 1)'(NEUTRAL_CURRENT_SAMPLE);
  assign cur_mag = cur_diff[SAMPLE_W] ? (SAMPLE_W + 1)'(-cur_diff)
                                      : cur_diff;
  assign mismatch_evt = SAMPLE_VALID
                        & (cur_mag > {1'b0, threshold_r[SAMPLE_W-1:0]});

  ////////////////////////////////////////////////////////////////////////////
  // Event collection

  logic [31:0] set_low;
  logic [31:0] set_high;

  always_comb begin
    set_low = 32'h0000_0000;
    set_low[EN_TOT_ACT] = half_full_evt[0];
    set_low[EN_FUND_ACT] = half_full_evt[1];
    set_low[EN_TOT_REACT] = half_full_evt[2];
    set_low[EN_FUND_REACT] = half_full_evt[3];
    set_low[EN_APPARENT] = half_full_evt[4];
    set_low[EN_LINE_CYC] = LINE_CYCLE_DONE & LINE_CYCLE_MODE;
    set_low[EN_SIGN_PC:EN_SIGN_PA] = sign_chg[2:0];
    set_low[EN_PSUM1] = sign_chg[3];
    set_low[EN_REACT_A] = sign_chg[4];
  end

  always_comb begin
    set_high = 32'h0000_0000;
    set_high[BIT_MISMATCH] = mismatch_evt;
    set_high[BIT_CURRENT_PEAK_VALUE] = CURRENT_PEAK_DONE;
    set_high[BIT_VOLTAGE_PEAK_VALUE] = VOLTAGE_PEAK_DONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status words

  logic [31:0] status_low_r;
  logic [31:0] status_low_nxt;
  logic [31:0] status_high_r;
  logic [31:0] status_high_nxt;
  logic [31:0] clr_low;
  logic [31:0] clr_high;

  // A new event in the clearing cycle wins over the clear.
  assign clr_low = wr_status_low ? wr.data : 32'h0000_0000;
  assign clr_high = wr_status_high ? wr.data : 32'h0000_0000;
  assign status_low_nxt = ((status_low_r & ~clr_low) | set_low) & LOW_MASK;
  assign status_high_nxt = ((status_high_r & ~clr_high) | set_high) & HIGH_FLAG_MASK;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_low_r <= STATUS_LOW_RST;
    end else begin
      status_low_r <= status_low_nxt;
    end
  end

  // The reset-done flag comes up set and stays until software clears it.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      status_high_r <= STATUS_HIGH_RST;
    end else begin
      status_high_r <= status_high_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] status_high_view;

  always_comb begin
    status_high_view = status_high_r & HIGH_FLAG_MASK;
    status_high_view[BIT_FIXED_ONE] = 1'b1;
    status_high_view[BIT_FIXED_ZERO] = 1'b0;
  end

  always_comb begin
    case (rd.idx)
      IDX_STATUS_LOW: rd_data = status_low_r;
      IDX_STATUS_HIGH: rd_data = status_high_view;
      IDX_ENABLE_LOW: rd_data = enable_low_r;
      IDX_ENABLE_HIGH: rd_data = enable_high_r;
      IDX_THRESHOLD: rd_data = threshold_r;
      IDX_ACCUMULATION_MODE_REG: rd_data = accumulation_mode_reg_r;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt lines

  logic irq0_r;
  logic second_irq_line_r;
  logic [31:0] pend_low_nxt;
  logic [31:0] pend_high_nxt;

  // Next enables are used so a newly written mask acts at the edge of the write.
  assign pend_low_nxt = status_low_nxt & enable_low_nxt;
  assign pend_high_nxt = status_high_nxt & enable_high_nxt;

  // Registered so the lines are glitch-free pins; fed from the next-state terms, they change at the same edge as the status words.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq0_r <= 1'b1;
    end else begin
      irq0_r <= ~|pend_low_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      second_irq_line_r <= 1'b1;
    end else begin
      second_irq_line_r <= ~(|pend_high_nxt | status_high_nxt[BIT_RESET_DONE]);
    end
  end

  assign IRQ0_N = irq0_r;
  assign SECOND_IRQ_LINE_N = second_irq_line_r;

endmodule

// ===== mefe_pkg.sv
package mefe_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam int unsigned IDX_W = 18;
  localparam logic [17:0] IDX_STATUS_LOW = 18'h0e502;
  localparam logic [17:0] IDX_STATUS_HIGH = 18'h0e503;
  localparam logic [17:0] IDX_ENABLE_LOW = 18'h0e50a;
  localparam logic [17:0] IDX_ENABLE_HIGH = 18'h0e50b;
  localparam logic [17:0] IDX_THRESHOLD = 18'h0e50c;
  localparam logic [17:0] IDX_ACCUMULATION_MODE_REG = 18'h0e50d;

  // Bit positions of the second status word.
  localparam int unsigned BIT_RESET_DONE = 15;
  localparam int unsigned BIT_MISMATCH = 20;
  localparam int unsigned BIT_FIXED_ONE = 21;
  localparam int unsigned BIT_FIXED_ZERO = 22;
  localparam int unsigned BIT_CURRENT_PEAK_VALUE = 23;
  localparam int unsigned BIT_VOLTAGE_PEAK_VALUE = 24;

  // Bit positions of the first enable word and its matching status word.
  localparam int unsigned EN_TOT_ACT = 0;
  localparam int unsigned EN_FUND_ACT = 1;
  localparam int unsigned EN_TOT_REACT = 2;
  localparam int unsigned EN_FUND_REACT = 3;
  localparam int unsigned EN_APPARENT = 4;
  localparam int unsigned EN_LINE_CYC = 5;
  localparam int unsigned EN_SIGN_PA = 6;
  localparam int unsigned EN_SIGN_PC = 8;
  localparam int unsigned EN_PSUM1 = 9;
  localparam int unsigned EN_REACT_A = 10;
  localparam int unsigned LOW_USED = 11;

  // Accumulation mode register fields.
  localparam int unsigned ACC_ACT_SEL_BIT = 6;
  localparam int unsigned ACC_REACT_SEL_BIT = 7;

  // Reset values and fixed masks.
  localparam logic [31:0] STATUS_LOW_RST = 32'h0000_0000;
  localparam logic [31:0] STATUS_HIGH_RST = 32'h0000_8000;
  localparam logic [31:0] HIGH_FLAG_MASK = 32'h0190_8000;
  localparam logic [31:0] HIGH_ENABLE_MASK = 32'h0190_0000;
  localparam logic [31:0] LOW_MASK = 32'h0000_07ff;
  localparam logic [31:0] ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] THRESHOLD_RST = 32'h0000_0000;
  localparam logic [31:0] ACCUMULATION_MODE_REG_RST = 32'h0000_0000;
  localparam logic [31:0] ACCUMULATION_MODE_REG_MASK = 32'h0000_00c0;

  // Width of the current samples from the datapath.
  localparam int unsigned SAMPLE_W = 28;

  typedef struct packed {
    logic en;
    logic [17:0] idx;
    logic [31:0] data;
  } mefe_wr_s;

  typedef struct packed {
    logic en;
    logic [17:0] idx;
  } mefe_rd_s;

  typedef enum logic [1:0] {
    AHB_IDLE = 2'b00,
    AHB_WR = 2'b01,
    AHB_RD = 2'b10,
    AHB_RDOUT = 2'b11
  } mefe_ahb_e;

endpackage

// ===== mefe_change_det.sv
`timescale 1ns/1ps
module mefe_change_det
  import mefe_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic valid,
  input wire logic [W-1:0] d,
  output logic [W-1:0] chg
);

  logic [W-1:0] prev_r;
  logic armed_r;

  // The first sample after reset only primes the history, so no false event.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (valid) begin
      armed_r <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_r[i] <= 1'b0;
        end else if (valid) begin
          prev_r[i] <= d[i];
        end
      end
      assign chg[i] = valid & armed_r & (d[i] ^ prev_r[i]);
    end
  endgenerate

endmodule

// ===== mefe_ahb_slave.sv
`timescale 1ns/1ps
module mefe_ahb_slave
  import mefe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output mefe_wr_s wr,
  output mefe_rd_s rd,
  input wire logic [31:0] rd_data
);

  mefe_ahb_e state_r;
  logic [17:0] idx_r;
  logic accept;
  logic addr_ok;

  assign accept = hsel & htrans[1] & hready;
  // Misaligned or out-of-window addresses map to index zero, which is unmapped.
  assign addr_ok = (haddr[31:20] == 12'h000) & (haddr[1:0] == 2'b00);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= AHB_IDLE;
      idx_r <= 18'h00000;
    end else if (accept) begin
      state_r <= hwrite ? AHB_WR : AHB_RD;
      idx_r <= addr_ok ? haddr[19:2] : 18'h00000;
    end else begin
      case (state_r)
        AHB_RD: state_r <= AHB_RDOUT;
        AHB_WR: state_r <= AHB_IDLE;
        AHB_RDOUT: state_r <= AHB_IDLE;
        default: state_r <= AHB_IDLE;
      endcase
    end
  end

  // One wait state on reads lets a write in the previous data phase land first.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (state_r == AHB_RD) begin
      hrdata <= rd_data;
    end
  end

  assign hreadyout = (state_r != AHB_RD);
  assign hresp = 1'b0;
  assign wr.en = (state_r == AHB_WR);
  assign wr.idx = idx_r;
  assign wr.data = hwdata;
  assign rd.en = (state_r == AHB_RD);
  assign rd.idx = idx_r;

endmodule

// ===== mefe_top_sva.sv
`timescale 1ns/1ps
module mefe_top_sva
  import mefe_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic [31:0] HRDATA,
  input wire logic HRESP,
  input wire logic IRQ0_N,
  input wire logic SECOND_IRQ_LINE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic take, rd_hi, wph_r;
  assign take = HSEL && HTRANS[1] && HREADY;
  assign rd_hi = take && !HWRITE && HADDR == {12'h000, IDX_STATUS_HIGH, 2'b00};
  // Flags clear only at the end of a write data phase, so a released line needs one.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      wph_r <= 1'b0;
    end else begin
      wph_r <= take && HWRITE;
    end
  end
  ////////////////////////////////////////
  AST_HRESP_OKAY: assert property (HRESP == 1'b0) else $error("error response seen");
  AST_READ_WAIT: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (take && HWRITE |=> HREADYOUT)
    else $error("write data phase stalled");
  AST_FIXED_ONE: assert property (rd_hi |-> ##2 HRDATA[21])
    else $error("status bit 21 not one");
  AST_FIXED_ZERO: assert property (rd_hi |-> ##2 !HRDATA[22])
    else $error("status bit 22 not zero");
  AST_HIGH_ZERO: assert property (rd_hi |-> ##2 HRDATA[31:25] == 7'h00)
    else $error("status bits 31 to 25 not zero");
  AST_RST_DONE_IRQ: assert property ($rose(RST_N) |=> !SECOND_IRQ_LINE_N)
    else $error("second line not low after reset");
  AST_IRQ0_IDLE: assert property ($rose(RST_N) |=> IRQ0_N ##1 IRQ0_N)
    else $error("first line low with enables at reset value");
  AST_SECOND_IRQ_LINE_CLEAR: assert property ($rose(SECOND_IRQ_LINE_N) |-> $past(wph_r))
    else $error("second line released without a write");
  AST_IRQ0_CLEAR: assert property ($rose(IRQ0_N) |-> $past(wph_r))
    else $error("first line released without a write");
  cover property (rd_hi);
  cover property ($fell(IRQ0_N));
  cover property ($rose(SECOND_IRQ_LINE_N));
endmodule
bind mefe_top mefe_top_sva u_sva (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
  .HRDATA(HRDATA), .HRESP(HRESP), .IRQ0_N(IRQ0_N), .SECOND_IRQ_LINE_N(SECOND_IRQ_LINE_N));

// ===== mefe_bench.sv
`timescale 1ns/1ps
module mefe_bench
  import mefe_pkg::*;
;
  logic clk, rst_n, hsel, hwrite, hready, hresp, sv, lcm, lcd, irq0_n, second_irq_line_n;
  logic [1:0] htrans, pk;
  logic [31:0] haddr, hwdata, hrdata;
  logic [14:0] e30;
  logic [8:0] sg;
  logic signed [SAMPLE_W-1:0] summed_phase_current, ineu;
  int mismatches, samples_checked;
  mefe_top dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready),
    .HRDATA(hrdata), .HRESP(hresp), .SAMPLE_VALID(sv), .SUMMED_PHASE_CURRENT(summed_phase_current),
    .NEUTRAL_CURRENT_SAMPLE(ineu), .CURRENT_PEAK_DONE(pk[0]), .VOLTAGE_PEAK_DONE(pk[1]),
    .TOTAL_ACTIVE_BIT30(e30[2:0]), .FUND_ACTIVE_BIT30(e30[5:3]),
    .TOTAL_REACTIVE_BIT30(e30[8:6]), .FUND_REACTIVE_BIT30(e30[11:9]),
    .APPARENT_BIT30(e30[14:12]), .LINE_CYCLE_MODE(lcm), .LINE_CYCLE_DONE(lcd),
    .TOTAL_ACTIVE_SIGN(sg[2:0]), .FUND_ACTIVE_SIGN(sg[5:3]), .PULSE1_SUM_SIGN(sg[6]),
    .TOTAL_REACTIVE_SIGN_A(sg[7]), .FUND_REACTIVE_SIGN_A(sg[8]), .IRQ0_N(irq0_n),
    .SECOND_IRQ_LINE_N(second_irq_line_n));
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is looked at mid-cycle, where it is settled, then the deciding edge is taken.
  task automatic wt(output logic [31:0] d);
    logic r;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      r = hready;
      d = hrdata;
      @(posedge clk);
    end
  endtask
  task automatic xfer(input logic w, input logic [17:0] i, input logic [31:0] wd,
      output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {12'h000, i, 2'b00};
    wt(d);
    htrans <= 2'b00;
    hwdata <= wd;
    wt(d);
  endtask
  task automatic wr(input logic [17:0] i, input logic [31:0] v);
    logic [31:0] x;
    xfer(1'b1, i, v, x);
  endtask
  task automatic rdc(input logic [17:0] i, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, i, 32'h0, x);
    chk(x, e);
  endtask
  task automatic irq(input logic e0, input logic e1);
    @(negedge clk);
    chk({30'h0, second_irq_line_n, irq0_n}, {30'h0, e1, e0});
    @(posedge clk);
  endtask
  task automatic judge(input int b, input logic m);
    irq(b < 0 || m, 1'b1);
    rdc(IDX_STATUS_LOW, (b < 0) ? 32'h0 : 32'h1 << b);
    wr(IDX_STATUS_LOW, 32'h7ff);
    irq(1'b1, 1'b1);
  endtask
  task automatic step(input logic [23:0] v, input int b, input logic m);
    {sg, e30} <= v;
    @(posedge clk);
    judge(b, m);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    irq(1'b1, 1'b0);
    rdc(IDX_STATUS_HIGH, 32'h0020_8000);
    rdc(IDX_ENABLE_LOW, 32'h0);
    wr(IDX_STATUS_HIGH, 32'hffff_ffff);
    irq(1'b1, 1'b1);
    rdc(IDX_STATUS_HIGH, 32'h0020_0000);
    wr(IDX_ENABLE_LOW, 32'hffff_ffff);
    rdc(IDX_ENABLE_LOW, 32'h0000_07ff);
    wr(18'h00001, 32'hffff_ffff);
    rdc(18'h00001, 32'h0);
    $display("reset and register test done");
  endtask
  task automatic t_events;
    int sx[9] = '{6, 7, 8, -1, -1, -1, 9, 10, -1};
    int ci[7] = '{18, 19, 20, 23, 15, 16, 17};
    int cx[7] = '{6, 7, 8, 10, -1, -1, -1};
    for (int k = 0; k < 24; k++) begin
      step((24'h1 << (k + 1)) - 24'h1, (k < 15) ? k / 3 : sx[k - 15], 1'b0);
    end
    // Both sign sources are equal here, so switching the select raises no event.
    wr(IDX_ACCUMULATION_MODE_REG, 32'h0000_00c0);
    for (int k = 0; k < 7; k++) begin
      step({sg, e30} & ~(24'h1 << ci[k]), cx[k], 1'b0);
    end
    wr(IDX_ENABLE_LOW, 32'h0);
    step({sg, e30} ^ 24'h1, 0, 1'b1);
    wr(IDX_ENABLE_LOW, 32'h20);
    for (int m = 0; m < 2; m++) begin
      lcm <= m[0];
      lcd <= 1'b1;
      @(posedge clk);
      lcd <= 1'b0;
      judge((m == 0) ? -1 : 5, 1'b0);
    end
    $display("low event test done");
  endtask
  task automatic t_high;
    for (int p = 0; p < 2; p++) begin
      pk <= 2'h1 << p;
      @(posedge clk);
      pk <= 2'h0;
      irq(1'b1, 1'b1);
      rdc(IDX_STATUS_HIGH, 32'h0020_0000 | (32'h1 << (23 + p)));
      wr(IDX_ENABLE_HIGH, 32'h1 << (23 + p));
      irq(1'b1, 1'b0);
      wr(IDX_STATUS_HIGH, 32'h1 << (23 + p));
      irq(1'b1, 1'b1);
    end
    wr(IDX_ENABLE_HIGH, 32'h0010_0000);
    wr(IDX_THRESHOLD, 32'h0000_0064);
    summed_phase_current <= 28'sh32;
    for (int n = 0; n < 2; n++) begin
      ineu <= (n == 0) ? -28'sh32 : -28'sh33;
      sv <= 1'b1;
      @(posedge clk);
      sv <= 1'b0;
      irq(1'b1, n == 0);
      rdc(IDX_STATUS_HIGH, (n == 0) ? 32'h0020_0000 : 32'h0030_0000);
      wr(IDX_STATUS_HIGH, 32'h0010_0000);
    end
    $display("high status test done");
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #125000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    sv = 1'b0;
    summed_phase_current = 28'sh0;
    ineu = 28'sh0;
    pk = 2'h0;
    e30 = 15'h0;
    sg = 9'h0;
    lcm = 1'b0;
    lcd = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_events();
    t_high();
    report_and_stop();
  end
endmodule
